/* File: shared/ovr_pkg.sv */
// Purpose: Shared constants and types for the input overvoltage reaction block.
// Assumes: Command codes are decoded upstream into a code plus strobe.
// Notes:   Reset values of the two registers are neutral defaults.
package ovr_pkg;

  // Command codes of the two registers reached from the link
  localparam logic [7:0]  CMD_OV_THRESHOLD = 8'h55;
  localparam logic [7:0]  CMD_OV_REACTION  = 8'h56;

  // Reset values
  localparam logic [7:0]  REACTION_RESET   = 8'hc0;
  localparam logic [15:0] THRESHOLD_RESET  = 16'h7bff;

  // Field positions in the reaction register
  localparam int MODE_MSB  = 7;
  localparam int MODE_LSB  = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;

  // Response modes
  localparam logic [1:0]  MODE_IGNORE = 2'h0;
  localparam logic [1:0]  MODE_RUNON  = 2'h1;
  localparam logic [1:0]  MODE_RETRY  = 2'h2;
  localparam logic [1:0]  MODE_LATCH  = 2'h3;

  // Retry field codes with special meaning
  localparam logic [2:0]  RETRY_NONE    = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER = 3'h7;

  // Linear numeric format: 5-bit signed exponent over 11-bit signed mantissa
  localparam int          LIN_EXP_MSB  = 15;
  localparam int          LIN_EXP_LSB  = 11;
  localparam int          LIN_MANT_MSB = 10;
  localparam logic [5:0]  LIN_BIAS     = 6'h10;
  localparam int          LIN_SCALED_W = 42;

  // Delay timer width: 16-bit unit shifted by up to 7
  localparam int          TIMER_W = 24;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_OFF,
    ST_RUN,
    ST_RUNON,
    ST_RETRY_WAIT,
    ST_LATCHED
  } ovr_state_t;

endpackage

/* File: core/ovr_link_regs.sv */
// Purpose: Link-side copy of the reaction and threshold registers.
// Assumes: Requests arrive decoded: code, write strobe, size flag, data.
// Notes:   A write is passed to the core by a toggle handshake.
`timescale 1ns/1ps
module ovr_link_regs
  import ovr_pkg::*;
(
  input  wire logic        link_clk,     // Link clock
  input  wire logic        link_rst_b,   // Link reset, synchronous
  input  wire logic [7:0]  link_cmd,     // Command code
  input  wire logic        link_wr,      // Write strobe
  input  wire logic        link_word,    // 1 word transfer, 0 byte
  input  wire logic [15:0] link_wdata,   // Write data
  input  wire logic        ack_tgl,      // Core acknowledge toggle
  output logic      [15:0] link_rdata_q, // Read data for link_cmd
  output logic             link_busy_q,  // Write still crossing
  output logic             req_tgl_q,    // Request toggle to core
  output logic      [7:0]  reaction_q,   // Held reaction register
  output logic      [15:0] threshold_q   // Held threshold register
);

  typedef struct packed {
    logic        ack_s1;
    logic        ack_s2;
    logic        ack_s3;
    logic        ack_lvl;
    logic        req;
    logic        busy;
    logic [7:0]  reaction;
    logic [15:0] threshold;
    logic [15:0] rdata;
  } ovr_link_t;

  ovr_link_t s;
  ovr_link_t n;
  logic      accept;
  logic      busy_now;

  // Handshake, register writes and read mux
  always_comb begin
    n        = s;
    n.ack_s1 = ack_tgl;
    n.ack_s2 = s.ack_s1;
    n.ack_s3 = s.ack_s2;
    if (s.ack_s2 == s.ack_s3) begin
      n.ack_lvl = s.ack_s3;
    end
    busy_now = s.req != s.ack_lvl;
    accept   = link_wr && !busy_now;
    if (accept && !link_word && link_cmd == CMD_OV_REACTION) begin
      n.reaction = link_wdata[7:0]; // RULE1
      n.req      = ~s.req;
    end else if (accept && link_word && link_cmd == CMD_OV_THRESHOLD) begin
      n.threshold = link_wdata; // RULE18
      n.req       = ~s.req;
    end
    n.busy = n.req != n.ack_lvl;
    unique case (link_cmd)
      CMD_OV_REACTION:  n.rdata = {8'h00, n.reaction}; // RULE1
      CMD_OV_THRESHOLD: n.rdata = n.threshold;
      default:          n.rdata = 16'h0000;
    endcase
  end

  // State register
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      s           <= '0;
      s.reaction  <= REACTION_RESET;
      s.threshold <= THRESHOLD_RESET;
    end else begin
      s <= n;
    end
  end

  assign link_rdata_q = s.rdata;
  assign link_busy_q  = s.busy;
  assign req_tgl_q    = s.req;
  assign reaction_q   = s.reaction;
  assign threshold_q  = s.threshold;

endmodule

/* File: core/ovr_fault_seq.sv */
// Purpose: Input overvoltage fault reaction sequencer with link-side registers.
// Assumes: Voltage sample and delay unit arrive on clk; control pin is async.
// Notes:   Register values cross from the link clock by toggle handshake.
//
// Overview of operation
// [RULE1] Reaction register is one read/write byte
// [RULE2] Mode 00 keeps output running through fault
// [RULE3] Mode 01 runs on for delay first
// [RULE4] Mode 01 rechecks fault when delay expires
// [RULE5] After run-on, retry field sets restart
// [RULE6] Mode 10 disables at once, then retries
// [RULE7] Mode 11 latches off until cleared
// [RULE8] Status clear, clear-faults or reset unlatch
// [RULE9] Commanding off then on also unlatches
// [RULE10] Retry code 000 makes no restart
// [RULE11] Codes 001..110 retry that many times
// [RULE12] Restart spacing is multiplier times unit
// [RULE13] Code 111 retries until commanded off
// [RULE14] Another shutdown fault stops endless retrying
// [RULE15] Delay field selects two to the field
// [RULE16] Same multiplier for run-on and spacing
// [RULE17] Base unit comes from a separate register
// [RULE18] Fault is input above linear threshold
// [RULE19] Clear or off resets counter and timer
// [RULE20] Attempt fails if fault still present
`timescale 1ns/1ps
module ovr_fault_seq
  import ovr_pkg::*;
(
  input  wire logic        clk,            // Core clock, 200 MHz
  input  wire logic        rst_b,          // Core reset, synchronous, low
  input  wire logic        link_clk,       // Link clock
  input  wire logic        link_rst_b,     // Link reset, synchronous, low
  input  wire logic [7:0]  link_cmd,       // Command code
  input  wire logic        link_wr,        // Write strobe
  input  wire logic        link_word,      // 1 word transfer, 0 byte
  input  wire logic [15:0] link_wdata,     // Write data
  output logic      [15:0] link_rdata_q,   // Read data
  output logic             link_busy_q,    // Write still crossing
  input  wire logic [15:0] vin_sample,     // Input voltage, linear format
  input  wire logic [15:0] delay_unit,     // Delay unit in clk cycles
  input  wire logic        ctrl_pin,       // Remote on/off pin, async
  input  wire logic        operation_on,   // On bit of the operation command
  input  wire logic        clear_faults,   // Clear-all-faults pulse
  input  wire logic        status_clr,     // Clear of this status bit
  input  wire logic        other_shutdown, // Another fault shut the unit down
  output logic             power_en_q,     // Output stage enable
  output logic             ov_status_q,    // Sticky overvoltage status
  output logic             latched_q       // Held off until cleared
);

  typedef struct packed {
    logic               ctrl_s1;
    logic               ctrl_s2;
    logic               ctrl_s3;
    logic               ctrl_lvl;
    logic               req_s1;
    logic               req_s2;
    logic               req_s3;
    logic               req_lvl;
    logic               ack;
    logic [7:0]         reaction;
    logic [15:0]        threshold;
    logic               ov_det;
    ovr_state_t         state;
    logic [TIMER_W-1:0] timer;
    logic [2:0]         attempts;
    logic               power_en;
    logic               status;
    logic               latched;
  } ovr_core_t;

  ovr_core_t          s;
  ovr_core_t          n;
  logic               req_tgl;
  logic [7:0]         reaction_hold;
  logic [15:0]        threshold_hold;
  logic               cmd_on;
  logic               clr;
  logic               expired;
  logic               go_retry;
  logic [1:0]         mode;
  logic [2:0]         retries;
  logic [2:0]         dly_sel;
  logic [15:0]        unit_eff;
  logic [TIMER_W-1:0] delay_m1;

  // Link-side registers and request toggle
  ovr_link_regs u_link (
    .link_clk     (link_clk),
    .link_rst_b   (link_rst_b),
    .link_cmd     (link_cmd),
    .link_wr      (link_wr),
    .link_word    (link_word),
    .link_wdata   (link_wdata),
    .ack_tgl      (s.ack),
    .link_rdata_q (link_rdata_q),
    .link_busy_q  (link_busy_q),
    .req_tgl_q    (req_tgl),
    .reaction_q   (reaction_hold),
    .threshold_q  (threshold_hold)
  );

  // Scale a linear value to a common fixed point; negatives read as zero
  function automatic logic [LIN_SCALED_W-1:0] lin_scale(input logic [15:0] v);
    logic [5:0]              sh;
    logic [LIN_SCALED_W-1:0] m;
    sh = {v[LIN_EXP_MSB], v[LIN_EXP_MSB:LIN_EXP_LSB]} + LIN_BIAS;
    m  = {{(LIN_SCALED_W-LIN_MANT_MSB){1'b0}}, v[LIN_MANT_MSB-1:0]};
    if (v[LIN_MANT_MSB]) begin
      lin_scale = '0;
    end else begin
      lin_scale = m << sh;
    end
  endfunction

  // Field decode and delay length
  always_comb begin
    mode     = s.reaction[MODE_MSB:MODE_LSB];
    retries  = s.reaction[RETRY_MSB:RETRY_LSB];
    dly_sel  = s.reaction[DELAY_MSB:DELAY_LSB];
    // A zero unit would stall the timer, so treat it as one cycle
    unit_eff = (delay_unit == 16'h0000) ? 16'h0001 : delay_unit; // RULE17
    // Two to the field value times the unit, minus one for the down count
    delay_m1 = ({{(TIMER_W-16){1'b0}}, unit_eff} << dly_sel) - TIMER_W'(1); // RULE15 RULE16
  end

  // Next-state logic for the whole core
  always_comb begin
    n        = s;
    go_retry = 1'b0;

    // Control pin: three stages, accept once stages two and three agree
    n.ctrl_s1 = ctrl_pin;
    n.ctrl_s2 = s.ctrl_s1;
    n.ctrl_s3 = s.ctrl_s2;
    if (s.ctrl_s2 == s.ctrl_s3) begin
      n.ctrl_lvl = s.ctrl_s3;
    end

    // Request toggle from the link, same three-stage treatment
    n.req_s1 = req_tgl;
    n.req_s2 = s.req_s1;
    n.req_s3 = s.req_s2;
    if (s.req_s2 == s.req_s3) begin
      n.req_lvl = s.req_s3;
    end

    // Link holds its copy stable until the acknowledge returns
    if (s.req_lvl != s.ack) begin
      n.reaction  = reaction_hold;
      n.threshold = threshold_hold;
      n.ack       = s.req_lvl;
    end

    // Overvoltage compare against the stored threshold
    n.ov_det = lin_scale(vin_sample) > lin_scale(s.threshold); // RULE18

    cmd_on  = s.ctrl_lvl & operation_on;
    clr     = clear_faults | status_clr;
    expired = s.timer == '0;

    // Delay timer counts down while nonzero
    if (!expired) begin
      n.timer = s.timer - TIMER_W'(1);
    end

    // Sticky status: a new detection beats a clear in the same cycle
    if (clr) begin
      n.status = 1'b0;
    end
    if (s.ov_det) begin
      n.status = 1'b1;
    end

    if (!cmd_on) begin
      // Commanded off: drop output, forget retries and timer
      n.state    = ST_OFF; // RULE9 RULE13
      n.power_en = 1'b0;
      n.attempts = 3'h0; // RULE19
      n.timer    = '0; // RULE19
      n.latched  = 1'b0;
    end else begin
      unique case (s.state)
        ST_OFF: begin
          // Turn on, which also releases an earlier latch
          n.state    = ST_RUN; // RULE9
          n.power_en = 1'b1;
          n.attempts = 3'h0;
          n.timer    = '0;
        end
        ST_RUN: begin
          n.power_en = 1'b1;
          if (s.ov_det) begin
            unique case (mode)
              MODE_IGNORE: begin
                n.state = ST_RUN; // RULE2
              end
              MODE_RUNON: begin
                // Keep running for the delay before acting
                n.state = ST_RUNON; // RULE3
                n.timer = delay_m1; // RULE16
              end
              MODE_RETRY: begin
                go_retry = 1'b1; // RULE6
              end
              MODE_LATCH: begin
                n.state    = ST_LATCHED; // RULE7
                n.power_en = 1'b0;
                n.latched  = 1'b1;
              end
            endcase
          end
        end
        ST_RUNON: begin
          n.power_en = 1'b1;
          if (expired) begin
            if (s.ov_det) begin
              go_retry = 1'b1; // RULE4 RULE5
            end else begin
              n.state = ST_RUN; // RULE4
            end
          end
        end
        ST_RETRY_WAIT: begin
          n.power_en = 1'b0;
          if (other_shutdown) begin
            // Another fault took the unit down: stop retrying
            n.state    = ST_LATCHED; // RULE14
            n.latched  = 1'b1;
            n.timer    = '0;
          end else if (clr) begin
            n.state    = ST_RUN; // RULE8 RULE19
            n.power_en = 1'b1;
            n.attempts = 3'h0;
            n.timer    = '0;
          end else if (expired) begin
            if (!s.ov_det) begin
              // Restart succeeds
              n.state    = ST_RUN; // RULE11
              n.power_en = 1'b1;
              n.attempts = 3'h0;
            end else if (retries == RETRY_FOREVER) begin
              n.timer = delay_m1; // RULE13 RULE20 RULE12
            end else if (s.attempts + 3'h1 < retries) begin
              // Failed attempt, more remain
              n.attempts = s.attempts + 3'h1; // RULE20 RULE11
              n.timer    = delay_m1; // RULE12
            end else begin
              // Every attempt failed: hold off
              n.state    = ST_LATCHED; // RULE11
              n.latched  = 1'b1;
              n.attempts = 3'h0;
            end
          end
        end
        ST_LATCHED: begin
          n.power_en = 1'b0;
          if (clr) begin
            // Released by status clear or clear-faults
            n.state    = ST_RUN; // RULE8
            n.power_en = 1'b1;
            n.latched  = 1'b0;
            n.attempts = 3'h0; // RULE19
            n.timer    = '0;
          end
        end
        default: begin
          n.state    = ST_OFF;
          n.power_en = 1'b0;
        end
      endcase

      // Shut down and take restart behaviour from the retry field
      if (go_retry) begin
        n.power_en = 1'b0; // RULE6
        n.attempts = 3'h0;
        if (retries == RETRY_NONE) begin
          n.state   = ST_LATCHED; // RULE10
          n.latched = 1'b1;
          n.timer   = '0;
        end else begin
          // First attempt starts one interval after shutdown
          n.state = ST_RETRY_WAIT; // RULE5 RULE12
          n.timer = delay_m1;
        end
      end
    end
  end

  // Single state register; reset also clears any latch
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s           <= '0; // RULE8
      s.reaction  <= REACTION_RESET;
      s.threshold <= THRESHOLD_RESET;
      s.state     <= ST_OFF;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign power_en_q  = s.power_en;
  assign ov_status_q = s.status;
  assign latched_q   = s.latched;

endmodule

/* File: verification/ovr_fault_seq_monitor.sv */
// Purpose: Concurrent checks on the ports of the overvoltage reaction block.
// Assumes: Both resets are synchronous and active low.
// Notes:   Attached by bind; sees ports only.
`timescale 1ns/1ps
module ovr_fault_seq_monitor
  import ovr_pkg::*;
(
  input wire logic        clk,          // Core clock
  input wire logic        rst_b,        // Core reset
  input wire logic        link_clk,     // Link clock
  input wire logic        link_rst_b,   // Link reset
  input wire logic [7:0]  link_cmd,     // Command code
  input wire logic        link_wr,      // Write strobe
  input wire logic [15:0] link_rdata_q, // Read data
  input wire logic        link_busy_q,  // Write crossing
  input wire logic        ctrl_pin,     // Remote on/off pin
  input wire logic        operation_on, // Operation on bit
  input wire logic        clear_faults, // Clear-all pulse
  input wire logic        status_clr,   // Status clear pulse
  input wire logic        power_en_q,   // Output enable
  input wire logic        ov_status_q,  // Sticky status
  input wire logic        latched_q     // Held off
);
  // Core domain
  property p_rst_quiet;
    @(posedge clk) disable iff (!rst_b) $rose(rst_b) |-> !power_en_q && !latched_q && !ov_status_q;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not quiet after reset");
  property p_latched_off;
    @(posedge clk) disable iff (!rst_b) latched_q |-> !power_en_q;
  endproperty
  a_latched_off: assert property (p_latched_off) else $error("output on while latched");
  property p_off_cmd;
    @(posedge clk) disable iff (!rst_b) $fell(operation_on) |-> ##[1:4] !power_en_q;
  endproperty
  a_off_cmd: assert property (p_off_cmd) else $error("output kept on after off command");
  property p_clear_latch;
    @(posedge clk) disable iff (!rst_b) latched_q && (status_clr || clear_faults) |-> ##[1:3] !latched_q;
  endproperty
  a_clear_latch: assert property (p_clear_latch) else $error("latch not released by clear");
  property p_sticky;
    @(posedge clk) disable iff (!rst_b)
      ov_status_q && !status_clr && !clear_faults && operation_on && ctrl_pin |=> ov_status_q;
  endproperty
  a_sticky: assert property (p_sticky) else $error("status dropped without clear");
  property p_rise_cmd;
    @(posedge clk) disable iff (!rst_b) $rose(power_en_q) |-> $past(operation_on) && !latched_q;
  endproperty
  a_rise_cmd: assert property (p_rise_cmd) else $error("output rose without on command");
  // Link domain
  property p_busy_cause;
    @(posedge link_clk) disable iff (!link_rst_b) $rose(link_busy_q) |-> $past(link_wr);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without write");
  property p_busy_bound;
    @(posedge link_clk) disable iff (!link_rst_b) $rose(link_busy_q) |-> ##[1:40] !link_busy_q;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("write crossing never ends");
  property p_rdata_other;
    @(posedge link_clk) disable iff (!link_rst_b)
      $past(link_cmd) != CMD_OV_THRESHOLD && $past(link_cmd) != CMD_OV_REACTION && $stable(link_cmd)
      |-> link_rdata_q == 16'h0000;
  endproperty
  a_rdata_other: assert property (p_rdata_other) else $error("unmapped code read not zero");
  property p_rdata_byte;
    @(posedge link_clk) disable iff (!link_rst_b)
      $past(link_cmd) == CMD_OV_REACTION && $stable(link_cmd) |-> link_rdata_q[15:8] == 8'h00;
  endproperty
  a_rdata_byte: assert property (p_rdata_byte) else $error("byte register read too wide");
endmodule
bind ovr_fault_seq ovr_fault_seq_monitor u_ovr_fault_seq_monitor (
  .clk(clk), .rst_b(rst_b), .link_clk(link_clk), .link_rst_b(link_rst_b), .link_cmd(link_cmd),
  .link_wr(link_wr), .link_rdata_q(link_rdata_q), .link_busy_q(link_busy_q), .ctrl_pin(ctrl_pin),
  .operation_on(operation_on), .clear_faults(clear_faults), .status_clr(status_clr),
  .power_en_q(power_en_q), .ov_status_q(ov_status_q), .latched_q(latched_q));

/* File: verification/ovr_host_model.sv */
// Purpose: Host controller model speaking the decoded link register protocol.
// Assumes: Link inputs change at the falling link clock edge.
// Notes:   Write data is inverted once released so stale data never helps.
`timescale 1ns/1ps
module ovr_host_model (
  input  wire logic        link_clk,     // Link clock
  input  wire logic        link_busy_q,  // Write crossing flag
  input  wire logic [15:0] link_rdata_q, // Read data
  output logic      [7:0]  link_cmd,     // Command code
  output logic             link_wr,      // Write strobe
  output logic             link_word,    // Word transfer select
  output logic      [15:0] link_wdata    // Write data
);
  // Idle bus
  initial begin
    link_cmd   = 8'h00;
    link_wr    = 1'b0;
    link_word  = 1'b0;
    link_wdata = 16'h0000;
  end
  // One-strobe write, bounded waits on busy
  task automatic write_reg(input logic [7:0] c, input logic w, input logic [15:0] d, output logic ok);
    int i;
    ok = 1'b0;
    for (i = 0; i < 64 && !ok; i++) begin
      @(negedge link_clk);
      ok = !link_busy_q;
    end
    if (!ok) return;
    link_cmd   = c;
    link_word  = w;
    link_wdata = d;
    link_wr    = 1'b1;
    @(negedge link_clk);
    link_wr    = 1'b0;
    link_wdata = ~d; // Released data
    ok = 1'b0;
    for (i = 0; i < 64 && !ok; i++) begin
      @(negedge link_clk);
      ok = i > 0 && !link_busy_q;
    end
  endtask
  // Read: select code, take data two edges later
  task automatic read_reg(input logic [7:0] c, output logic [15:0] d);
    @(negedge link_clk);
    link_cmd = c;
    repeat (2) @(negedge link_clk);
    d = link_rdata_q;
  endtask
endmodule

/* File: verification/ovr_fault_seq_test.sv */
// Purpose: Self-checking bench for the overvoltage reaction block.
// Assumes: Threshold 50 and samples 40/60 share exponent 0; unit of 4, later 8 cycles.
// Notes:   Expected times carry a tolerance of three cycles.
`timescale 1ns/1ps
module ovr_fault_seq_test
  import ovr_pkg::*;
;
  localparam logic [15:0] LO = 16'h0028;
  localparam logic [15:0] HI = 16'h003c;
  localparam logic [2:0]  RT [5] = '{3'h0, 3'h1, 3'h3, 3'h6, 3'h2};
  localparam logic [2:0]  DL [5] = '{3'h0, 3'h2, 3'h1, 3'h0, 3'h7};
  logic        clk, rst_b, link_clk, link_rst_b, link_wr, link_word, link_busy_q, ok;
  logic [7:0]  link_cmd;
  logic [15:0] link_wdata, link_rdata_q, vin_sample, delay_unit, rd;
  logic        ctrl_pin, operation_on, clear_faults, status_clr, other_shutdown;
  logic        power_en_q, ov_status_q, latched_q;
  int          bad_count, compares, n;

  ovr_fault_seq u_ovr_fault_seq (.clk(clk), .rst_b(rst_b), .link_clk(link_clk), .link_rst_b(link_rst_b),
    .link_cmd(link_cmd), .link_wr(link_wr), .link_word(link_word), .link_wdata(link_wdata),
    .link_rdata_q(link_rdata_q), .link_busy_q(link_busy_q), .vin_sample(vin_sample), .delay_unit(delay_unit),
    .ctrl_pin(ctrl_pin), .operation_on(operation_on), .clear_faults(clear_faults), .status_clr(status_clr),
    .other_shutdown(other_shutdown), .power_en_q(power_en_q), .ov_status_q(ov_status_q), .latched_q(latched_q));
  ovr_host_model u_ovr_host_model (.link_clk(link_clk), .link_busy_q(link_busy_q), .link_rdata_q(link_rdata_q),
    .link_cmd(link_cmd), .link_wr(link_wr), .link_word(link_word), .link_wdata(link_wdata));

  // Clocks, link clock offset in phase
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end

  task automatic final_report;
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic near(input string nm, input int e, input int g);
    compares++;
    if (g < e - 3 || g > e + 3) begin
      bad_count++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic clks(input int c);
    repeat (c) @(negedge clk);
  endtask
  // Bounded wait for power (0) or latch (1) to reach a level
  task automatic wait_for(input logic which, input logic lvl, output int c);
    c = 0;
    while (((which ? latched_q : power_en_q) !== lvl) && c < 5000) begin
      @(negedge clk);
      c++;
    end
    if (c >= 5000) begin
      bad_count++;
      final_report();
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic w, input logic [15:0] d);
    u_ovr_host_model.write_reg(c, w, d, ok);
    if (!ok) begin
      bad_count++;
      final_report();
    end
    clks(20);
  endtask
  task automatic rchk(input logic [7:0] c, input logic [15:0] e);
    u_ovr_host_model.read_reg(c, rd);
    chk("link_rdata_q", e, rd);
  endtask
  // Clear by status bit, clear-all, operation off/on, pin off/on
  task automatic clear_by(input int k);
    case (k)
      0: status_clr = 1'b1;
      1: clear_faults = 1'b1;
      2: operation_on = 1'b0;
      default: ctrl_pin = 1'b0;
    endcase
    clks(8);
    status_clr   = 1'b0;
    clear_faults = 1'b0;
    operation_on = 1'b1;
    ctrl_pin     = 1'b1;
    clks(12);
  endtask

  // Main sequence
  initial begin
    bad_count = 0;
    compares = 0;
    rst_b = 1'b0;
    link_rst_b = 1'b0;
    vin_sample = LO;
    delay_unit = 16'h0004;
    ctrl_pin = 1'b1;
    operation_on = 1'b1;
    clear_faults = 1'b0;
    status_clr = 1'b0;
    other_shutdown = 1'b0;
    clks(6);
    rst_b = 1'b1;
    repeat (2) @(negedge link_clk);
    link_rst_b = 1'b1;
    clks(20);
    chk("power_en_q", 16'h1, power_en_q);
    rchk(CMD_OV_REACTION, {8'h00, REACTION_RESET});
    rchk(CMD_OV_THRESHOLD, THRESHOLD_RESET);
    rchk(8'h57, 16'h0000);
    wr(CMD_OV_THRESHOLD, 1'b1, 16'h0032);
    rchk(CMD_OV_THRESHOLD, 16'h0032);
    wr(CMD_OV_REACTION, 1'b1, 16'h00ff);
    rchk(CMD_OV_REACTION, {8'h00, REACTION_RESET});
    wr(CMD_OV_REACTION, 1'b0, 16'h0000);
    rchk(CMD_OV_REACTION, 16'h0000);
    // Ignore mode keeps running, status still sticky
    vin_sample = HI;
    clks(40);
    chk("power_en_q", 16'h1, power_en_q);
    vin_sample = LO;
    clks(5);
    chk("ov_status_q", 16'h1, ov_status_q);
    clear_by(0);
    chk("ov_status_q", 16'h0, ov_status_q);
    // Latch mode, each way of clearing
    wr(CMD_OV_REACTION, 1'b0, 16'h00c0);
    for (int k = 0; k < 4; k++) begin
      vin_sample = HI;
      clks(1);
      chk("power_en_q", 16'h1, power_en_q);
      clks(2);
      chk("power_en_q", 16'h0, power_en_q);
      vin_sample = LO;
      clks(30);
      chk("latched_q", 16'h1, latched_q);
      clear_by(k);
      chk("latched_q", 16'h0, latched_q);
      chk("power_en_q", 16'h1, power_en_q);
    end
    // Disable and retry with a persisting fault
    for (int i = 0; i < 5; i++) begin
      wr(CMD_OV_REACTION, 1'b0, {8'h00, 2'h2, RT[i], DL[i]});
      vin_sample = HI;
      wait_for(1'b0, 1'b0, n);
      wait_for(1'b1, 1'b1, n);
      near("retry_span", int'(RT[i]) * (4 << DL[i]), n);
      vin_sample = LO;
      clear_by(1);
      chk("power_en_q", 16'h1, power_en_q);
    end
    // Restart succeeds once the fault is gone
    wr(CMD_OV_REACTION, 1'b0, 16'h0089);
    vin_sample = HI;
    clks(3);
    vin_sample = LO;
    wait_for(1'b0, 1'b0, n);
    wait_for(1'b0, 1'b1, n);
    near("restart_gap", 8, n);
    chk("latched_q", 16'h0, latched_q);
    // Run-on mode with a larger unit: short fault passes, long fault acts after the delay
    delay_unit = 16'h0008;
    wr(CMD_OV_REACTION, 1'b0, 16'h0052);
    vin_sample = HI;
    clks(8);
    chk("power_en_q", 16'h1, power_en_q);
    vin_sample = LO;
    clks(40);
    chk("power_en_q", 16'h1, power_en_q);
    vin_sample = HI;
    wait_for(1'b0, 1'b0, n);
    near("runon", 34, n);
    wait_for(1'b1, 1'b1, n);
    near("runon_retry", 64, n);
    vin_sample = LO;
    clear_by(1);
    // Endless retry, stopped by another fault and by off command
    wr(CMD_OV_REACTION, 1'b0, 16'h00b8);
    vin_sample = HI;
    clks(200);
    chk("latched_q", 16'h0, latched_q);
    other_shutdown = 1'b1;
    clks(1);
    other_shutdown = 1'b0;
    clks(5);
    chk("latched_q", 16'h1, latched_q);
    vin_sample = LO;
    clear_by(1);
    vin_sample = HI;
    clks(50);
    operation_on = 1'b0;
    clks(5);
    vin_sample = LO;
    clks(30);
    chk("power_en_q", 16'h0, power_en_q);
    chk("latched_q", 16'h0, latched_q);
    operation_on = 1'b1;
    clks(12);
    chk("power_en_q", 16'h1, power_en_q);
    final_report();
  end
endmodule
